// ### verilog/sipec_pkg.sv
package sipec_pkg;

  // Legacy prefix byte encodings.
  localparam logic [7:0] PFX_OPSIZE = 8'h66;
  localparam logic [7:0] PFX_ADDR   = 8'h67;
  localparam logic [7:0] PFX_LOCK   = 8'hF0;
  localparam logic [7:0] PFX_REP    = 8'hF3;
  localparam logic [7:0] PFX_REPNE  = 8'hF2;
  localparam logic [7:0] PFX_SEG_ES = 8'h26;
  localparam logic [7:0] PFX_SEG_CS = 8'h2E;
  localparam logic [7:0] PFX_SEG_SS = 8'h36;
  localparam logic [7:0] PFX_SEG_DS = 8'h3E;
  localparam logic [7:0] PFX_SEG_FS = 8'h64;
  localparam logic [7:0] PFX_SEG_GS = 8'h65;

  // Segment register indices handed to address generation.
  localparam logic [2:0] SEG_ES = 3'h0;
  localparam logic [2:0] SEG_CS = 3'h1;
  localparam logic [2:0] SEG_SS = 3'h2;
  localparam logic [2:0] SEG_DS = 3'h3;
  localparam logic [2:0] SEG_FS = 3'h4;
  localparam logic [2:0] SEG_GS = 3'h5;

  // Exception vectors.
  localparam logic [7:0] VEC_UD = 8'h06;
  localparam logic [7:0] VEC_NP = 8'h0B;
  localparam logic [7:0] VEC_GP = 8'h0D;
  localparam logic [7:0] VEC_PF = 8'h0E;
  localparam logic [7:0] VEC_MF = 8'h10;
  localparam logic [7:0] VEC_NONE = 8'h00;

  // Geometry of the shared register file.
  localparam int          NUM_PFX   = 4;
  localparam int          NUM_REGS  = 8;
  localparam int          REG_W     = 80;
  localparam int          MANT_W    = 64;
  localparam logic [15:0] EXP_ONES  = 16'hFFFF;
  localparam logic [1:0]  TAG_VALID = 2'h0;
  localparam logic [1:0]  TAG_EMPTY = 2'h3;
  localparam logic [2:0]  TOP_RESET = 3'h0;
  localparam logic [15:0] TAGS_RESET = 16'hFFFF;

  // Operand-size and repeat prefixes fault when set, else are ignored.
  localparam logic RESV_PFX_FAULTS = 1'b1;

  // Sequencer states, Gray coded along idle, hold, restart.
  typedef enum logic [1:0]
  {
    SIPEC_IDLE    = 2'b00,
    SIPEC_HOLD    = 2'b01,
    SIPEC_RESTART = 2'b11
  } sipec_state_t;

endpackage : sipec_pkg

// ### verilog/sipec_check.sv
// Function
// [RULE1] Memory faults reported like any memory instruction.
// [RULE2] No numeric fault without a pending one.
// [RULE3] Pending error signals vector sixteen and/or pin.
// [RULE4] Restart faulting instruction after handler returns.
// [RULE5] Integer registers alias floating registers and tags.
// [RULE6] Address-size prefix applies only with memory operand.
// [RULE7] Segment overrides apply only with memory operand.
// [RULE8] Operand-size and repeat prefixes are reserved.
// [RULE9] Lock prefix always raises invalid opcode.
// [RULE10] Branch hints without memory operand are reserved.
// [RULE11] Non-empty-state instruction zeroes top, validates tags.
// [RULE12] Invalid opcode outranks pending numeric error.
module sipec_check
(
  // Clock and reset.
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  // Instruction issue from decode.
  input  wire logic                 ins_valid,
  output logic                      ins_ready,
  input  wire logic                 ins_empty_state,
  input  wire logic                 ins_has_mem,
  input  wire logic [2:0]           ins_pfx_count,
  input  wire logic [3:0][7:0]      ins_pfx_bytes,
  input  wire logic                 ins_wr_en,
  input  wire logic [2:0]           ins_wr_idx,
  input  wire logic [63:0]          ins_wr_data,
  // Memory access status for the issued instruction.
  input  wire logic                 mem_page_fault,
  input  wire logic                 mem_seg_not_present,
  input  wire logic                 mem_limit_violation,
  // Floating-point exception state and handler return.
  input  wire logic                 fp_exc_pending,
  input  wire logic                 cfg_numeric_vector,
  input  wire logic                 handler_return,
  // Result of each issued instruction.
  output logic                      res_valid,
  output logic                      res_complete,
  output logic                      res_fault,
  output logic [7:0]                res_vector,
  output logic                      invalid_opcode_fault,
  output logic                      res_reserved,
  output logic                      eff_addr_toggle,
  output logic                      eff_seg_valid,
  output logic [2:0]                eff_seg,
  output logic                      numeric_error_out_n,
  output logic                      restart_req,
  // Floating-point side of the shared storage, and the SIMD read view.
  input  wire logic                 fp_wr_en,
  input  wire logic [2:0]           fp_wr_idx,
  input  wire logic [79:0]          fp_wr_data,
  input  wire logic                 fp_tag_wr_en,
  input  wire logic [15:0]          fp_tag_wr_data,
  input  wire logic                 fp_top_wr_en,
  input  wire logic [2:0]           fp_top_wr_data,
  input  wire logic [2:0]           fp_rd_idx,
  output logic [79:0]               fp_rd_data,
  input  wire logic [2:0]           simd_rd_idx,
  output logic [63:0]               simd_rd_data,
  output logic [15:0]               tag_word,
  output logic [2:0]                stack_top_index
);

  ////////////////////////////////////////////////////////////////////////////////
  // Prefix classification.

  logic       pf_lock;
  logic       pf_resv;
  logic       pf_addr;
  logic       pf_seg;
  logic [2:0] pf_seg_idx;

  // Scans the present prefixes; a later segment override replaces an earlier one.
  always_comb
  begin
    pf_lock    = 1'b0;
    pf_resv    = 1'b0;
    pf_addr    = 1'b0;
    pf_seg     = 1'b0;
    pf_seg_idx = sipec_pkg::SEG_DS;
    for (int i = 0; i < sipec_pkg::NUM_PFX; i++)
    begin
      if (3'(i) < ins_pfx_count)
      begin
        unique case (ins_pfx_bytes[i])
          sipec_pkg::PFX_LOCK:   pf_lock = 1'b1;
          sipec_pkg::PFX_OPSIZE,
          sipec_pkg::PFX_REP,
          sipec_pkg::PFX_REPNE:  pf_resv = 1'b1;
          sipec_pkg::PFX_ADDR:   pf_addr = 1'b1;
          sipec_pkg::PFX_SEG_ES:
          begin
            pf_seg     = 1'b1;
            pf_seg_idx = sipec_pkg::SEG_ES;
          end
          sipec_pkg::PFX_SEG_CS:
          begin
            pf_seg     = 1'b1;
            pf_seg_idx = sipec_pkg::SEG_CS;
          end
          sipec_pkg::PFX_SEG_SS:
          begin
            pf_seg     = 1'b1;
            pf_seg_idx = sipec_pkg::SEG_SS;
          end
          sipec_pkg::PFX_SEG_DS:
          begin
            pf_seg     = 1'b1;
            pf_seg_idx = sipec_pkg::SEG_DS;
          end
          sipec_pkg::PFX_SEG_FS:
          begin
            pf_seg     = 1'b1;
            pf_seg_idx = sipec_pkg::SEG_FS;
          end
          sipec_pkg::PFX_SEG_GS:
          begin
            pf_seg     = 1'b1;
            pf_seg_idx = sipec_pkg::SEG_GS;
          end
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Issue sequencer and result registers.

  sipec_pkg::sipec_state_t state;
  sipec_pkg::sipec_state_t next_state;
  logic       take;
  logic       ud_hit;
  logic       mf_hit;
  logic       mem_hit;
  logic       done;
  logic       next_res_valid;
  logic       next_res_complete;
  logic       next_res_fault;
  logic [7:0] next_res_vector;
  logic       next_ud;
  logic       next_res_reserved;
  logic       next_addr_toggle;
  logic       next_seg_valid;
  logic [2:0] next_seg;
  logic       next_err_n;
  logic       next_restart;

  // Only one instruction is in flight, so a held numeric error blocks issue.
  assign ins_ready = (state == sipec_pkg::SIPEC_IDLE);
  assign take      = ins_valid && ins_ready;
  assign ud_hit    = pf_lock || (pf_resv && sipec_pkg::RESV_PFX_FAULTS); // see [RULE9] [RULE8]
  assign mf_hit    = !ud_hit && fp_exc_pending; // see [RULE12] [RULE2]
  assign mem_hit   = ins_has_mem &&
                     (mem_page_fault || mem_seg_not_present || mem_limit_violation);
  assign done      = take && !ud_hit && !mf_hit && !mem_hit;

  // Decide each issued instruction; decode faults precede execution faults.
  always_comb
  begin
    next_state        = state;
    next_res_valid    = take;
    next_res_complete = done;
    next_res_fault    = take && !done;
    next_res_vector   = sipec_pkg::VEC_NONE;
    next_ud           = 1'b0;
    next_res_reserved = 1'b0;
    next_addr_toggle  = 1'b0;
    next_seg_valid    = 1'b0;
    next_seg          = sipec_pkg::SEG_DS;
    next_err_n        = numeric_error_out_n;
    next_restart      = 1'b0;
    unique case (state)
      sipec_pkg::SIPEC_IDLE:
      begin
        if (take)
        begin
          // Address-size and segment prefixes without a memory operand are ignored and flagged. see [RULE6] [RULE7] [RULE10]
          next_res_reserved = (!ins_has_mem && (pf_addr || pf_seg)) || pf_resv;
          next_addr_toggle  = ins_has_mem && pf_addr; // see [RULE6]
          next_seg_valid    = ins_has_mem && pf_seg; // see [RULE7]
          next_seg          = pf_seg_idx;
          if (ud_hit)
          begin
            next_ud         = 1'b1; // see [RULE9] [RULE12]
            next_res_vector = sipec_pkg::VEC_UD;
          end
          else if (mf_hit)
          begin
            // Pin always drops; the vector is reported when enabled. see [RULE3]
            next_err_n      = 1'b0;
            next_res_fault  = cfg_numeric_vector;
            next_res_vector = cfg_numeric_vector ? sipec_pkg::VEC_MF : sipec_pkg::VEC_NONE;
            next_state      = sipec_pkg::SIPEC_HOLD;
          end
          else if (mem_hit)
          begin
            // Same priority and vectors as any other memory access. see [RULE1]
            if (mem_page_fault)
              next_res_vector = sipec_pkg::VEC_PF;
            else if (mem_seg_not_present)
              next_res_vector = sipec_pkg::VEC_NP;
            else
              next_res_vector = sipec_pkg::VEC_GP;
          end
        end
      end
      sipec_pkg::SIPEC_HOLD:
      begin
        if (handler_return)
        begin
          next_err_n = 1'b1;
          next_state = sipec_pkg::SIPEC_RESTART;
        end
      end
      sipec_pkg::SIPEC_RESTART:
      begin
        // Fetch re-issues the same instruction, which then runs normally. see [RULE4]
        next_restart = 1'b1;
        next_state   = sipec_pkg::SIPEC_IDLE;
      end
      default:
        next_state = sipec_pkg::SIPEC_IDLE;
    endcase
  end

  // Registers of the sequencer and the result.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state                <= sipec_pkg::SIPEC_IDLE;
      res_valid            <= 1'b0;
      res_complete         <= 1'b0;
      res_fault            <= 1'b0;
      res_vector           <= sipec_pkg::VEC_NONE;
      invalid_opcode_fault <= 1'b0;
      res_reserved         <= 1'b0;
      eff_addr_toggle      <= 1'b0;
      eff_seg_valid        <= 1'b0;
      eff_seg              <= sipec_pkg::SEG_DS;
      numeric_error_out_n  <= 1'b1;
      restart_req          <= 1'b0;
    end
    else
    begin
      state                <= next_state;
      res_valid            <= next_res_valid;
      res_complete         <= next_res_complete;
      res_fault            <= next_res_fault;
      res_vector           <= next_res_vector;
      invalid_opcode_fault <= next_ud;
      res_reserved         <= next_res_reserved;
      eff_addr_toggle      <= next_addr_toggle;
      eff_seg_valid        <= next_seg_valid;
      eff_seg              <= next_seg;
      numeric_error_out_n  <= next_err_n;
      restart_req          <= next_restart;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared register storage, tags and stack top.

  logic [sipec_pkg::REG_W-1:0] regs      [sipec_pkg::NUM_REGS];
  logic [sipec_pkg::REG_W-1:0] next_regs [sipec_pkg::NUM_REGS];
  logic [15:0]                 next_tags;
  logic [2:0]                  next_top;

  // One physical array serves both views, so writes by either side are seen
  // by the other. A completing integer write overrides a floating write.
  always_comb
  begin
    next_tags = tag_word;
    next_top  = stack_top_index;
    for (int r = 0; r < sipec_pkg::NUM_REGS; r++)
      next_regs[r] = regs[r];
    if (fp_wr_en)
      next_regs[fp_wr_idx] = fp_wr_data; // see [RULE5]
    if (fp_tag_wr_en)
      next_tags = fp_tag_wr_data;
    if (fp_top_wr_en)
      next_top = fp_top_wr_data;
    if (done && ins_wr_en)
      next_regs[ins_wr_idx] = {sipec_pkg::EXP_ONES, ins_wr_data}; // see [RULE5]
    if (done)
    begin
      if (ins_empty_state)
        next_tags = {sipec_pkg::NUM_REGS{sipec_pkg::TAG_EMPTY}};
      else
      begin
        next_tags = {sipec_pkg::NUM_REGS{sipec_pkg::TAG_VALID}}; // see [RULE11]
        next_top  = sipec_pkg::TOP_RESET; // see [RULE11]
      end
    end
  end

  // Registers of the storage; data is not reset, control state is.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      tag_word        <= sipec_pkg::TAGS_RESET;
      stack_top_index <= sipec_pkg::TOP_RESET;
    end
    else
    begin
      tag_word        <= next_tags;
      stack_top_index <= next_top;
    end
  end

  // Register contents, held without reset to keep the array plain.
  always_ff @(posedge clk_sys)
  begin
    for (int r = 0; r < sipec_pkg::NUM_REGS; r++)
      regs[r] <= next_regs[r];
  end

  // Both read views index the same flops. see [RULE5]
  assign fp_rd_data   = regs[fp_rd_idx];
  assign simd_rd_data = regs[simd_rd_idx][sipec_pkg::MANT_W-1:0];

endmodule : sipec_check

// ### tb/sipec_check_asserts.sv
module sipec_check_asserts
(
  // Clock and reset.
  input wire logic             clk_sys,
  input wire logic             rstn,
  // Issue side.
  input wire logic             ins_valid,
  input wire logic             ins_ready,
  input wire logic             ins_empty_state,
  input wire logic             ins_has_mem,
  input wire logic [2:0]       ins_pfx_count,
  input wire logic [3:0][7:0]  ins_pfx_bytes,
  input wire logic             mem_page_fault,
  input wire logic             fp_exc_pending,
  input wire logic             handler_return,
  // Results.
  input wire logic             res_complete,
  input wire logic             res_fault,
  input wire logic [7:0]       res_vector,
  input wire logic             invalid_opcode_fault,
  input wire logic             numeric_error_out_n,
  input wire logic             restart_req,
  input wire logic [15:0]      tag_word,
  input wire logic [2:0]       stack_top_index
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // Take, lock-in-front and prefix-free take, shared by the properties.
  logic tk;
  logic lk;
  logic bare;
  assign tk   = ins_valid && ins_ready;
  assign lk   = ins_pfx_count != 3'h0 && ins_pfx_bytes[0] == sipec_pkg::PFX_LOCK;
  assign bare = tk && ins_pfx_count == 3'h0;

  property p_memf;
    bare && ins_has_mem && !fp_exc_pending && mem_page_fault |=> res_fault && res_vector == 8'h0E;
  endproperty
  a_memf: assert property (p_memf) else $error("page fault not reported");
  property p_nopend;
    $fell(numeric_error_out_n) |-> $past(tk && fp_exc_pending);
  endproperty
  a_nopend: assert property (p_nopend) else $error("numeric error without cause");
  property p_pend;
    bare && fp_exc_pending |=> !numeric_error_out_n && !ins_ready;
  endproperty
  a_pend: assert property (p_pend) else $error("pending error not signalled");
  property p_restart;
    !numeric_error_out_n && handler_return |=> numeric_error_out_n ##1 restart_req ##1 !restart_req;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart after handler");
  property p_resv;
    tk && ins_pfx_count == 3'h1 && ins_pfx_bytes[0] inside {8'h66, 8'hF3, 8'hF2}
      |=> invalid_opcode_fault;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved prefix not faulted");
  property p_lock;
    tk && lk |=> invalid_opcode_fault && res_vector == 8'h06 && !res_complete;
  endproperty
  a_lock: assert property (p_lock) else $error("lock prefix not faulted");
  property p_state;
    bare && !fp_exc_pending && !ins_has_mem && !ins_empty_state
      |=> res_complete && tag_word == 16'h0000 && stack_top_index == 3'h0;
  endproperty
  a_state: assert property (p_state) else $error("tags or top not reset");
  property p_order;
    tk && lk && fp_exc_pending |=> invalid_opcode_fault && numeric_error_out_n && ins_ready;
  endproperty
  a_order: assert property (p_order) else $error("decode fault lost priority");
endmodule : sipec_check_asserts

bind sipec_check sipec_check_asserts chk_u
(
  .clk_sys, .rstn, .ins_valid, .ins_ready, .ins_empty_state, .ins_has_mem, .ins_pfx_count,
  .ins_pfx_bytes, .mem_page_fault, .fp_exc_pending, .handler_return, .res_complete,
  .res_fault, .res_vector, .invalid_opcode_fault, .numeric_error_out_n, .restart_req,
  .tag_word, .stack_top_index
);

// ### tb/sipec_check_test.sv
module sipec_check_test;
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////
  // Signals of the block under test.
  logic        clk_sys, rstn, ins_valid, ins_empty_state, ins_has_mem, ins_wr_en;
  logic        mem_page_fault, mem_seg_not_present, mem_limit_violation, fp_exc_pending;
  logic        cfg_numeric_vector, handler_return, fp_wr_en, fp_tag_wr_en, fp_top_wr_en;
  logic [2:0]  ins_pfx_count, ins_wr_idx, fp_wr_idx, fp_top_wr_data, fp_rd_idx, simd_rd_idx;
  logic [31:0] ins_pfx_bytes;
  logic [63:0] ins_wr_data, simd_rd_data;
  logic [79:0] fp_wr_data, fp_rd_data;
  logic [15:0] fp_tag_wr_data, tag_word;
  logic [7:0]  res_vector;
  logic [2:0]  eff_seg, stack_top_index;
  logic        ins_ready, res_valid, res_complete, res_fault, invalid_opcode_fault;
  logic        res_reserved, eff_addr_toggle, eff_seg_valid, numeric_error_out_n, restart_req;
  int          err_count, checks;

  sipec_check dut_u
  (
    .clk_sys, .rstn, .ins_valid, .ins_ready, .ins_empty_state, .ins_has_mem, .ins_pfx_count,
    .ins_pfx_bytes, .ins_wr_en, .ins_wr_idx, .ins_wr_data, .mem_page_fault,
    .mem_seg_not_present, .mem_limit_violation, .fp_exc_pending, .cfg_numeric_vector,
    .handler_return, .res_valid, .res_complete, .res_fault, .res_vector, .invalid_opcode_fault,
    .res_reserved, .eff_addr_toggle, .eff_seg_valid, .eff_seg, .numeric_error_out_n,
    .restart_req, .fp_wr_en, .fp_wr_idx, .fp_wr_data, .fp_tag_wr_en, .fp_tag_wr_data,
    .fp_top_wr_en, .fp_top_wr_data, .fp_rd_idx, .fp_rd_data, .simd_rd_idx, .simd_rd_data,
    .tag_word, .stack_top_index
  );

  ////////////////////////////////////////////////////////////
  // Shared compare and issue tasks.
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // An idle edge comes first so that valid is never raised in the step that lowered it.
  task automatic iss(input logic [31:0] pb, input logic [2:0] n, input logic m);
    @(posedge clk_sys) #1;
    ins_pfx_bytes = pb;
    ins_pfx_count = n;
    ins_has_mem = m;
    ins_valid = 1'b1;
    repeat (20) if (ins_ready !== 1'b1) @(posedge clk_sys) #1;
    @(posedge clk_sys) #1;
    ins_valid = 1'b0;
    chk(res_valid, 1'b1);
  endtask : iss

  task automatic t_pfx;
    logic [7:0] seg [6];
    logic [7:0] bad [4];
    seg = '{8'h26, 8'h2E, 8'h36, 8'h3E, 8'h64, 8'h65};
    bad = '{8'h66, 8'hF3, 8'hF2, 8'hF0};
    for (int i = 0; i < 6; i++)
    begin
      iss({24'h0, seg[i]}, 3'h1, 1'b1);
      chk({eff_seg_valid, eff_seg, res_reserved}, {1'b1, i[2:0], 1'b0});
      iss({24'h0, seg[i]}, 3'h1, 1'b0);
      chk({eff_seg_valid, res_reserved, invalid_opcode_fault}, 3'b010);
    end
    iss({16'h0, 8'h2E, 8'h65}, 3'h2, 1'b1);
    chk(eff_seg, 3'h1);
    iss(32'h67, 3'h1, 1'b1);
    chk({eff_addr_toggle, res_reserved}, 2'b10);
    iss(32'h67, 3'h1, 1'b0);
    chk({eff_addr_toggle, res_reserved}, 2'b01);
    for (int i = 0; i < 4; i++)
    begin
      iss({24'h0, bad[i]}, 3'h1, 1'b1);
      chk({invalid_opcode_fault, res_complete, res_vector}, {2'b10, 8'h06});
    end
    iss({8'hF0, 24'h2E_2E2E}, 3'h4, 1'b1);
    chk(invalid_opcode_fault, 1'b1);
    $display("prefix test done");
  endtask : t_pfx

  // Flags are {has_mem, page, not_present, limit}; faults rank page, not present, limit.
  task automatic t_mem;
    logic [3:0] mf [5];
    logic [7:0] ev [5];
    mf = '{4'hF, 4'hB, 4'h9, 4'h8, 4'h7};
    ev = '{8'h0E, 8'h0B, 8'h0D, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++)
    begin
      {mem_page_fault, mem_seg_not_present, mem_limit_violation} = mf[i][2:0];
      iss(32'h0, 3'h0, mf[i][3]);
      chk({res_fault, res_complete, res_vector}, {|ev[i], ~|ev[i], ev[i]});
    end
    {mem_page_fault, mem_seg_not_present, mem_limit_violation} = 3'h0;
    $display("memory fault test done");
  endtask : t_mem

  task automatic t_num;
    for (int c = 0; c < 2; c++)
    begin
      cfg_numeric_vector = c[0];
      fp_exc_pending = 1'b1;
      mem_page_fault = 1'b1;
      iss(32'h0, 3'h0, 1'b1);
      chk({res_fault, numeric_error_out_n, ins_ready, res_complete}, {c[0], 3'h0});
      chk(res_vector, c[0] ? 8'h10 : 8'h00);
      @(posedge clk_sys) #1;
      ins_valid = 1'b1;
      repeat (3) @(posedge clk_sys) #1 chk({res_valid, numeric_error_out_n}, 2'b00);
      ins_valid = 1'b0;
      fp_exc_pending = 1'b0;
      mem_page_fault = 1'b0;
      handler_return = 1'b1;
      @(posedge clk_sys) #1;
      handler_return = 1'b0;
      chk({numeric_error_out_n, restart_req}, 2'b10);
      @(posedge clk_sys) #1;
      chk({restart_req, ins_ready}, 2'b11);
      iss(32'h0, 3'h0, 1'b0);
      chk({res_complete, res_fault, numeric_error_out_n}, 3'b101);
    end
    fp_exc_pending = 1'b1;
    iss(32'hF0, 3'h1, 1'b0);
    chk({invalid_opcode_fault, numeric_error_out_n, ins_ready}, 3'b111);
    fp_exc_pending = 1'b0;
    $display("numeric test done");
  endtask : t_num

  task automatic t_alias;
    @(posedge clk_sys) #1;
    {fp_wr_en, fp_top_wr_en, fp_tag_wr_en} = 3'h7;
    fp_wr_idx = 3'h2;
    fp_wr_data = 80'h1234_5678_9ABC_DEF0_1357;
    fp_top_wr_data = 3'h5;
    fp_tag_wr_data = 16'h5A5A;
    {fp_rd_idx, simd_rd_idx} = 6'h12;
    @(posedge clk_sys) #1;
    {fp_wr_en, fp_top_wr_en, fp_tag_wr_en} = 3'h0;
    chk(simd_rd_data, 64'h5678_9ABC_DEF0_1357);
    chk({tag_word, stack_top_index}, {16'h5A5A, 3'h5});
    // Floating writes in the completing cycle must lose to the integer side.
    ins_wr_en = 1'b1;
    ins_wr_data = 64'hA5A5_0F0F_3C3C_9696;
    {fp_wr_en, fp_top_wr_en, fp_tag_wr_en} = 3'h7;
    iss(32'h0, 3'h0, 1'b0);
    ins_wr_en = 1'b0;
    {fp_wr_en, fp_top_wr_en, fp_tag_wr_en} = 3'h0;
    chk(fp_rd_data, {16'hFFFF, 64'hA5A5_0F0F_3C3C_9696});
    chk({tag_word, stack_top_index}, 19'h0);
    fp_top_wr_en = 1'b1;
    @(posedge clk_sys) #1;
    fp_top_wr_en = 1'b0;
    ins_empty_state = 1'b1;
    iss(32'h0, 3'h0, 1'b0);
    ins_empty_state = 1'b0;
    chk({tag_word, stack_top_index}, {16'hFFFF, 3'h5});
    $display("alias test done");
  endtask : t_alias

  // A reset during a numeric hold must release the pin and free issue at once.
  task automatic t_rst;
    fp_exc_pending = 1'b1;
    iss(32'h0, 3'h0, 1'b0);
    chk(numeric_error_out_n, 1'b0);
    fp_exc_pending = 1'b0;
    rstn = 1'b0;
    repeat (2) @(posedge clk_sys) #1;
    chk({numeric_error_out_n, ins_ready, res_valid, tag_word, stack_top_index},
        {3'b110, 16'hFFFF, 3'h0});
    rstn = 1'b1;
    iss(32'h0, 3'h0, 1'b0);
    chk({res_complete, numeric_error_out_n, tag_word}, {2'b11, 16'h0000});
    $display("reset test done");
  endtask : t_rst

  task automatic stop_test;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////
  // Clock, watchdog well past the hundred or so cycles needed, and main sequence.
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  initial
  begin
    #20us;
    err_count++;
    stop_test();
  end

  initial
  begin
    {rstn, ins_valid, ins_empty_state, ins_has_mem, ins_wr_en, mem_page_fault} = '0;
    {mem_seg_not_present, mem_limit_violation, fp_exc_pending, cfg_numeric_vector} = '0;
    {handler_return, fp_wr_en, fp_tag_wr_en, fp_top_wr_en, ins_pfx_count, fp_rd_idx} = '0;
    {ins_wr_idx, fp_wr_idx, fp_top_wr_data, simd_rd_idx, ins_pfx_bytes, ins_wr_data} = '0;
    {fp_wr_data, fp_tag_wr_data} = '0;
    ins_wr_idx = 3'h2;
    repeat (8) @(posedge clk_sys);
    #1 chk({numeric_error_out_n, tag_word, stack_top_index}, {1'b1, 16'hFFFF, 3'h0});
    rstn = 1'b1;
    t_pfx();
    t_mem();
    t_num();
    t_alias();
    t_rst();
    stop_test();
  end
endmodule : sipec_check_test
